// [verilog/cfs_flags.sv]
// Operation
// - Stop bit clear halts clock on low-power halt; set makes it a no-op.
// - Accumulate overflow into accumulator bit 35 sets the high overflow flag.
// - BCD add carry out of bit 3 sets the half-carry flag.
// - Overflow into accumulator bit 31 sets the extension overflow flag.
// - Negative flag follows result MSB; zero flag set when result is zero.
// - Two's-complement overflow sets the overflow flag.
// - Carry or borrow sets carry; shifts and rotates chain through carry.
// - Three-bit priority mask, 0 to 7, masks interrupt requests.
// - Saturate mode with overflow makes accumulator transfers return limits.
// - Program bank sits above the program counter for fetch addresses.
// - Upper byte holds stop and flags; lower holds mask, saturate, bank.
// - Six 4-bit bank fields: four in extension register, program, stack.
// - Index and stack banks extend their registers; extended bank tops addresses.
// - Multiplier, multiplicand, 36-bit accumulator and two 8-bit modulo masks.
// - Byte address drives lines 15 to 0, bank drives lines 19 to 16.
// - Fetches and reset vectors are program space; everything else data space.
// - Sixteen banks of 64 Kbytes, chosen by the bank fields.
// - 16-bit fraction: sign bit 15, radix point between bits 15 and 14.
// - 32-bit fraction: sign bit 31, radix point between bits 31 and 30.
// - Accumulator: sign bit 35, extension bits 34 to 31, range -16 to +16.
// - Byte 0 of a word lies at the lower address.
// - Fetches are word aligned; misaligned words become two byte transfers.
//
// The APB register port and the address map are this design's own decisions.
module cfs_flags (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cfs_pkg::cfs_exec_s exec,
  output logic [15:0] result,
  output logic [15:0] xfer_data,
  input wire cfs_pkg::cfs_acc_s acc,
  output cfs_pkg::cfs_bus_s bus,
  output logic acc_busy,
  input wire logic [2:0] irq_level,
  output logic irq_take,
  input wire logic wake,
  output logic clock_stop
);

  logic [15:0] condition_flags_register;
  logic [15:0] ext;
  logic [3:0] sk;
  logic [15:0] mul;
  logic [15:0] mcand;
  logic [35:0] am;
  logic [7:0] x_modulo_mask;
  logic [7:0] y_modulo_mask;
  logic sign_pre;
  cfs_pkg::cfs_bst_e bst;
  logic [19:0] addr2;
  logic wr;
  logic mapped;

  // ==========================================================
  // Helpers
  // Bank field for an access kind
  function automatic logic [3:0] bank_of(input cfs_pkg::cfs_kind_e k,
    input logic [15:0] c, input logic [15:0] e, input logic [3:0] s);
    logic [3:0] b;
    b = 4'h0;
    unique case (k)
      cfs_pkg::K_FETCH, cfs_pkg::K_RVEC: b = c[cfs_pkg::CCR_PK_LSB +: 4];
      cfs_pkg::K_VEC: b = 4'h0;
      cfs_pkg::K_EXT: b = e[cfs_pkg::EXT_EK_LSB +: 4];
      cfs_pkg::K_X: b = e[cfs_pkg::EXT_XK_LSB +: 4];
      cfs_pkg::K_Y: b = e[cfs_pkg::EXT_YK_LSB +: 4];
      cfs_pkg::K_Z: b = e[cfs_pkg::EXT_ZK_LSB +: 4];
      cfs_pkg::K_STK: b = s;
    endcase
    return b;
  endfunction : bank_of

  // Register address decode
  function automatic logic is_mapped(input logic [7:0] a);
    return a == cfs_pkg::ADDR_CCR || a == cfs_pkg::ADDR_EXT
      || a == cfs_pkg::ADDR_SK || a == cfs_pkg::ADDR_MUL
      || a == cfs_pkg::ADDR_MCAND || a == cfs_pkg::ADDR_AM_LO
      || a == cfs_pkg::ADDR_AM_HI || a == cfs_pkg::ADDR_MASK
      || a == cfs_pkg::ADDR_STAT;
  endfunction : is_mapped

  assign mapped = is_mapped(paddr);
  assign wr = psel && penable && pready && pwrite && !pslverr;

  // ==========================================================
  // Arithmetic and flag generation
  logic [15:0] aa;
  logic [15:0] bb;
  logic [16:0] s;
  logic [15:0] r;
  logic co;
  logic vo;
  logic hc;
  logic arith;
  logic [4:0] lo5;
  logic [8:0] bcd;
  logic [31:0] prod;
  logic [35:0] addend;
  logic [35:0] am_sum;
  logic ovf35;
  logic ovf31;
  logic sat;

  // Byte operations run in the upper half so flags come from bit 15
  always_comb
  begin
    aa = exec.byte_op ? {exec.a[7:0], 8'h00} : exec.a;
    bb = exec.byte_op ? {exec.b[7:0], 8'h00} : exec.b;
    s = 17'h0;
    r = 16'h0;
    co = 1'b0;
    vo = 1'b0;
    hc = 1'b0;
    lo5 = {1'b0, exec.a[3:0]} + {1'b0, exec.b[3:0]};
    bcd = {1'b0, exec.a[7:0]} + {1'b0, exec.b[7:0]};
    arith = 1'b1;
    unique case (exec.op)
      cfs_pkg::OP_ADD:
      begin
        s = {1'b0, aa} + {1'b0, bb};
        r = s[15:0];
        co = s[16];
        vo = (aa[15] == bb[15]) && (s[15] != aa[15]);
      end
      cfs_pkg::OP_SUB:
      begin
        s = {1'b0, aa} - {1'b0, bb};
        r = s[15:0];
        co = s[16];
        vo = (aa[15] != bb[15]) && (s[15] != aa[15]);
      end
      cfs_pkg::OP_BCD:
      begin
        hc = lo5[4];
        if (hc || bcd[3:0] > 4'h9)
          bcd = bcd + 9'h006;
        if (bcd[8] || exec.a[7:0] + exec.b[7:0] > 9'h099)
          bcd = bcd + 9'h060;
        co = bcd[8] || ({1'b0, exec.a[7:0]} + {1'b0, exec.b[7:0]} > 9'h099);
        r = {bcd[7:0], 8'h00};
      end
      cfs_pkg::OP_ROL:
      begin
        r = {aa[14:0], 1'b0}
          | (exec.byte_op ? {7'h0, condition_flags_register[cfs_pkg::CCR_C], 8'h00}
                          : {15'h0, condition_flags_register[cfs_pkg::CCR_C]});
        co = aa[15];
        vo = r[15] ^ co;
      end
      cfs_pkg::OP_ROR:
      begin
        r = {condition_flags_register[cfs_pkg::CCR_C], aa[15:1]}
          & (exec.byte_op ? 16'hff00 : 16'hffff);
        co = exec.byte_op ? aa[8] : aa[0];
        vo = r[15] ^ co;
      end
      default:
        arith = 1'b0;
    endcase
  end

  // Fractional product, sign-extended into the accumulator format
  always_comb
  begin
    prod = 32'($signed(mul) * $signed(mcand));
    addend = {{4{prod[30]}}, prod[30:0], 1'b0};
    am_sum = am + addend;
    ovf35 = (am[cfs_pkg::AM_SIGN] == addend[cfs_pkg::AM_SIGN])
      && (am_sum[cfs_pkg::AM_SIGN] != am[cfs_pkg::AM_SIGN]);
    ovf31 = !(&am_sum[35:31] || ~|am_sum[35:31]);
    sat = condition_flags_register[cfs_pkg::CCR_SM] && (condition_flags_register[cfs_pkg::CCR_EV] || condition_flags_register[cfs_pkg::CCR_MV]);
  end

  // ==========================================================
  // Condition flags register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      condition_flags_register <= cfs_pkg::CCR_RST;
    else
    begin
      if (wr && paddr == cfs_pkg::ADDR_CCR)
        condition_flags_register <= pwdata[15:0];
      if (arith)
      begin
        condition_flags_register[cfs_pkg::CCR_N] <= r[15];
        condition_flags_register[cfs_pkg::CCR_Z] <= (r == 16'h0);
        condition_flags_register[cfs_pkg::CCR_V] <= vo;
        condition_flags_register[cfs_pkg::CCR_C] <= co;
        if (exec.op == cfs_pkg::OP_BCD)
          condition_flags_register[cfs_pkg::CCR_H] <= hc;
      end
      // Overflow flags stay set; a set beats a software clear
      if (exec.op == cfs_pkg::OP_MAC && ovf35)
        condition_flags_register[cfs_pkg::CCR_MV] <= 1'b1;
      if (exec.op == cfs_pkg::OP_MAC && ovf31)
        condition_flags_register[cfs_pkg::CCR_EV] <= 1'b1;
    end
  end

  // Extension fields and stack bank
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext <= cfs_pkg::EXT_RST;
      sk <= cfs_pkg::SK_RST;
    end
    else
    begin
      if (wr && paddr == cfs_pkg::ADDR_EXT)
        ext <= pwdata[15:0];
      if (wr && paddr == cfs_pkg::ADDR_SK)
        sk <= pwdata[3:0];
    end
  end

  // Multiply-accumulate register set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mul <= 16'h0;
      mcand <= 16'h0;
      am <= 36'h0;
      x_modulo_mask <= 8'h0;
      y_modulo_mask <= 8'h0;
      sign_pre <= 1'b0;
    end
    else
    begin
      if (wr && paddr == cfs_pkg::ADDR_MUL)
        mul <= pwdata[15:0];
      if (wr && paddr == cfs_pkg::ADDR_MCAND)
        mcand <= pwdata[15:0];
      if (wr && paddr == cfs_pkg::ADDR_AM_LO)
        am[31:0] <= pwdata;
      if (wr && paddr == cfs_pkg::ADDR_AM_HI)
        am[35:32] <= pwdata[3:0];
      if (wr && paddr == cfs_pkg::ADDR_MASK)
      begin
        x_modulo_mask <= pwdata[15:8];
        y_modulo_mask <= pwdata[7:0];
      end
      if (exec.op == cfs_pkg::OP_MAC)
      begin
        am <= am_sum;
        if (ovf35 || ovf31)
          sign_pre <= am[cfs_pkg::AM_SIGN];
      end
    end
  end

  // Results and accumulator transfers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      result <= 16'h0;
      xfer_data <= 16'h0;
    end
    else
    begin
      if (arith)
        result <= exec.byte_op ? {8'h00, r[15:8]} : r;
      if (exec.op == cfs_pkg::OP_TRANSFER_ACC_ROUNDED || exec.op == cfs_pkg::OP_TRANSFER_ACC_TRUNCATED)
      begin
        if (sat)
          xfer_data <= sign_pre ? cfs_pkg::SAT_NEG : cfs_pkg::SAT_POS;
        else if (exec.op == cfs_pkg::OP_TRANSFER_ACC_ROUNDED)
          xfer_data <= am[31:16] + {15'h0, am[15]};
        else
          xfer_data <= am[31:16];
      end
    end
  end

  // ==========================================================
  // Low-power halt and interrupt masking
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      clock_stop <= 1'b0;
    else if (exec.op == cfs_pkg::OP_STOP && !condition_flags_register[cfs_pkg::CCR_S])
      clock_stop <= 1'b1;
    else if (wake)
      clock_stop <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_take <= 1'b0;
    else
      irq_take <= irq_level > condition_flags_register[cfs_pkg::CCR_IP_LSB +: 3];
  end

  // ==========================================================
  // Address formation and misaligned split
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bst <= cfs_pkg::ST_IDLE;
      bus <= '0;
      addr2 <= 20'h0;
      acc_busy <= 1'b0;
    end
    else
    begin
      unique case (bst)
        cfs_pkg::ST_IDLE:
        begin
          bus.valid <= acc.valid;
          bus.prog <= acc.kind == cfs_pkg::K_FETCH
            || acc.kind == cfs_pkg::K_RVEC;
          bus.lane_hi <= acc.word || !acc.offs[0];
          bus.byte_sz <= !acc.word;
          bus.addr <= {bank_of(acc.kind, condition_flags_register, ext, sk), acc.offs};
          if (acc.kind == cfs_pkg::K_FETCH)
          begin
            bus.byte_sz <= 1'b0;
            bus.lane_hi <= 1'b1;
            bus.addr <= {condition_flags_register[cfs_pkg::CCR_PK_LSB +: 4], acc.offs[15:1], 1'b0};
          end
          else if (acc.valid && acc.word && acc.offs[0])
          begin
            bus.byte_sz <= 1'b1;
            addr2 <= {bank_of(acc.kind, condition_flags_register, ext, sk), acc.offs} + 20'h1;
            bst <= cfs_pkg::ST_SECOND;
            acc_busy <= 1'b1;
          end
        end
        cfs_pkg::ST_SECOND:
        begin
          bus.valid <= 1'b1;
          bus.byte_sz <= 1'b1;
          bus.lane_hi <= 1'b0;
          bus.addr <= addr2;
          bst <= cfs_pkg::ST_IDLE;
          acc_busy <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // APB slave, zero wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (!mapped || paddr[1:0] != 2'h0);
      prdata <= 32'h0;
      if (psel && !penable && !pwrite)
      begin
        unique case (paddr)
          cfs_pkg::ADDR_CCR: prdata <= {16'h0, condition_flags_register};
          cfs_pkg::ADDR_EXT: prdata <= {16'h0, ext};
          cfs_pkg::ADDR_SK: prdata <= {28'h0, sk};
          cfs_pkg::ADDR_MUL: prdata <= {16'h0, mul};
          cfs_pkg::ADDR_MCAND: prdata <= {16'h0, mcand};
          cfs_pkg::ADDR_AM_LO: prdata <= am[31:0];
          cfs_pkg::ADDR_AM_HI: prdata <= {28'h0, am[35:32]};
          cfs_pkg::ADDR_MASK: prdata <= {16'h0, x_modulo_mask, y_modulo_mask};
          cfs_pkg::ADDR_STAT: prdata <= {29'h0, acc_busy, sign_pre, clock_stop};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_stop;
    exec.op == cfs_pkg::OP_STOP && !condition_flags_register[cfs_pkg::CCR_S] |=> clock_stop;
  endproperty
  a_stop: assert property (p_stop) else $error("halt did not stop clock");

  property p_nop;
    exec.op == cfs_pkg::OP_STOP && condition_flags_register[cfs_pkg::CCR_S] && !clock_stop |=> !clock_stop;
  endproperty
  a_nop: assert property (p_nop) else $error("halt not a no-op");

  property p_mv;
    exec.op == cfs_pkg::OP_MAC && ovf35 |=> condition_flags_register[cfs_pkg::CCR_MV]
      ##1 (condition_flags_register[cfs_pkg::CCR_MV] || $past(wr && paddr == cfs_pkg::ADDR_CCR));
  endproperty
  a_mv: assert property (p_mv) else $error("high overflow flag missing");

  property p_ev;
    exec.op == cfs_pkg::OP_MAC && ovf31 |=> condition_flags_register[cfs_pkg::CCR_EV];
  endproperty
  a_ev: assert property (p_ev) else $error("extension overflow missing");

  property p_zero;
    exec.op == cfs_pkg::OP_ADD |=> condition_flags_register[cfs_pkg::CCR_Z] == (result == 16'h0);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_irq;
    irq_level > condition_flags_register[cfs_pkg::CCR_IP_LSB +: 3] |=> irq_take;
  endproperty
  a_irq: assert property (p_irq) else $error("unmasked request not taken");

  property p_sat;
    exec.op == cfs_pkg::OP_TRANSFER_ACC_TRUNCATED && sat
      |=> xfer_data == cfs_pkg::SAT_POS || xfer_data == cfs_pkg::SAT_NEG;
  endproperty
  a_sat: assert property (p_sat) else $error("no saturation");

  property p_fetch;
    acc.valid && !acc_busy && acc.kind == cfs_pkg::K_FETCH
      |=> bus.prog && bus.addr[0] == 1'b0
      && bus.addr[19:16] == $past(condition_flags_register[3:0]);
  endproperty
  a_fetch: assert property (p_fetch) else $error("bad fetch address");

  property p_split;
    acc.valid && !acc_busy && acc.word && acc.offs[0] && acc.kind != cfs_pkg::K_FETCH
      |=> bus.byte_sz && bus.lane_hi ##1 bus.valid && bus.byte_sz && !bus.lane_hi;
  endproperty
  a_split: assert property (p_split) else $error("misaligned word not split");

  property p_space;
    acc.valid && !acc_busy && acc.kind == cfs_pkg::K_STK |=> !bus.prog;
  endproperty
  a_space: assert property (p_space) else $error("stack tagged program");

endmodule : cfs_flags

// [verilog/cfs_pkg.sv]
package cfs_pkg;

  // ==========================================================
  // Register byte addresses on the APB
  localparam logic [7:0] ADDR_CCR = 8'h00;
  localparam logic [7:0] ADDR_EXT = 8'h04;
  localparam logic [7:0] ADDR_SK = 8'h08;
  localparam logic [7:0] ADDR_MUL = 8'h0c;
  localparam logic [7:0] ADDR_MCAND = 8'h10;
  localparam logic [7:0] ADDR_AM_LO = 8'h14;
  localparam logic [7:0] ADDR_AM_HI = 8'h18;
  localparam logic [7:0] ADDR_MASK = 8'h1c;
  localparam logic [7:0] ADDR_STAT = 8'h20;

  // ==========================================================
  // Condition flags register bit positions
  localparam int CCR_S = 15;
  localparam int CCR_MV = 14;
  localparam int CCR_H = 13;
  localparam int CCR_EV = 12;
  localparam int CCR_N = 11;
  localparam int CCR_Z = 10;
  localparam int CCR_V = 9;
  localparam int CCR_C = 8;
  localparam int CCR_IP_LSB = 5;
  localparam int CCR_SM = 4;
  localparam int CCR_PK_LSB = 0;

  // Extension register field positions
  localparam int EXT_EK_LSB = 12;
  localparam int EXT_XK_LSB = 8;
  localparam int EXT_YK_LSB = 4;
  localparam int EXT_ZK_LSB = 0;

  // Accumulator format positions
  localparam int AM_SIGN = 35;
  localparam int AM_EXT_LSB = 31;

  // ==========================================================
  // Reset values and saturation limits
  localparam logic [15:0] CCR_RST = 16'h80e0;
  localparam logic [15:0] EXT_RST = 16'h0000;
  localparam logic [3:0] SK_RST = 4'h0;
  localparam logic [15:0] SAT_POS = 16'h7fff;
  localparam logic [15:0] SAT_NEG = 16'h8000;

  // ==========================================================
  // Execution operations and access kinds
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_ADD = 4'h1,
    OP_SUB = 4'h2,
    OP_BCD = 4'h3,
    OP_ROL = 4'h4,
    OP_ROR = 4'h5,
    OP_MAC = 4'h6,
    OP_STOP = 4'h7,
    OP_TRANSFER_ACC_ROUNDED = 4'h8,
    OP_TRANSFER_ACC_TRUNCATED = 4'h9
  } cfs_op_e;

  typedef enum logic [2:0] {
    K_FETCH = 3'h0,
    K_RVEC = 3'h1,
    K_VEC = 3'h2,
    K_EXT = 3'h3,
    K_X = 3'h4,
    K_Y = 3'h5,
    K_Z = 3'h6,
    K_STK = 3'h7
  } cfs_kind_e;

  typedef enum logic [0:0] {
    ST_IDLE = 1'h0,
    ST_SECOND = 1'h1
  } cfs_bst_e;

  typedef struct packed {
    cfs_op_e op;
    logic byte_op;
    logic [15:0] a;
    logic [15:0] b;
  } cfs_exec_s;

  typedef struct packed {
    logic valid;
    cfs_kind_e kind;
    logic [15:0] offs;
    logic word;
  } cfs_acc_s;

  typedef struct packed {
    logic valid;
    logic prog;
    logic byte_sz;
    logic lane_hi;
    logic [19:0] addr;
  } cfs_bus_s;

endpackage : cfs_pkg

// [sim/cfs_flags_bench.sv]
module cfs_flags_bench;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // Signals and rows
  typedef struct packed {
    cfs_pkg::cfs_op_e op;
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] res;
    logic [3:0] nzvc;
    logic [3:0] msk;
  } cfs_row_s;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  cfs_pkg::cfs_exec_s exec = '0;
  logic [15:0] result;
  logic [15:0] xfer_data;
  cfs_pkg::cfs_acc_s acc = '0;
  cfs_pkg::cfs_bus_s bus;
  logic acc_busy;
  logic [2:0] irq_level = 3'h0;
  logic irq_take;
  logic wake = 1'b0;
  logic clock_stop;
  int fail_count = 0;
  int checks = 0;
  logic [31:0] rdat;
  logic rerr;
  logic [3:0] bank [0:4] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5};
  cfs_row_s rows [0:5] = '{
    '{cfs_pkg::OP_ADD, 16'h7fff, 16'h0001, 16'h8000, 4'ha, 4'hf},
    '{cfs_pkg::OP_ADD, 16'hffff, 16'h0001, 16'h0000, 4'h5, 4'hf},
    '{cfs_pkg::OP_SUB, 16'h0000, 16'h0001, 16'hffff, 4'h9, 4'hf},
    '{cfs_pkg::OP_ROL, 16'h8000, 16'h0000, 16'h0001, 4'h1, 4'hd},
    '{cfs_pkg::OP_ROR, 16'h0001, 16'h0000, 16'h8000, 4'h9, 4'hd},
    '{cfs_pkg::OP_SUB, 16'h0005, 16'h0005, 16'h0000, 4'h4, 4'hf}};

  // Clock
  always #50 pclk = ~pclk;

  cfs_flags u_cfs_flags (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .exec(exec), .result(result), .xfer_data(xfer_data),
    .acc(acc), .bus(bus), .acc_busy(acc_busy), .irq_level(irq_level),
    .irq_take(irq_take), .wake(wake), .clock_stop(clock_stop)
  );

  // ==========================================================
  // Tasks
  task results;
    $display("Comparisons %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
    begin
      $display("Testbench passed");
    end
    else
    begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One APB transfer; holds the request until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      fail_count++;
      results();
    end
  endtask : apb

  // One-cycle command, outputs settled after its edge
  task ex(input cfs_pkg::cfs_op_e op, input logic bo, input logic [15:0] a,
          input logic [15:0] b);
    @(posedge pclk);
    exec <= cfs_pkg::cfs_exec_s'{op, bo, a, b};
    @(posedge pclk);
    exec <= '0;
    #1;
  endtask : ex

  task ac(input cfs_pkg::cfs_kind_e k, input logic [15:0] o, input logic w);
    @(posedge pclk);
    acc <= cfs_pkg::cfs_acc_s'{1'b1, k, o, w};
    @(posedge pclk);
    acc <= '0;
    #1;
  endtask : ac

  task irq(input logic [2:0] lv, input logic exp);
    @(posedge pclk);
    irq_level <= lv;
    repeat (2) @(posedge pclk);
    #1;
    chk(32'(irq_take), 32'(exp));
  endtask : irq

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, cfs_pkg::ADDR_CCR, 32'h0);
    chk(rdat, 32'(cfs_pkg::CCR_RST));
    apb(1'b0, 8'h24, 32'h0);
    chk({rdat[30:0], rerr}, 32'h1);
    apb(1'b0, 8'h02, 32'h0);
    chk(32'(rerr), 32'h1);
    // Table of arithmetic cases
    for (int i = 0; i < 6; i++)
    begin
      ex(rows[i].op, 1'b0, rows[i].a, rows[i].b);
      chk(32'(result), 32'(rows[i].res));
      apb(1'b0, cfs_pkg::ADDR_CCR, 32'h0);
      chk(32'(rdat[11:8] & rows[i].msk), 32'(rows[i].nzvc));
    end
    // Decimal add and half carry
    ex(cfs_pkg::OP_BCD, 1'b1, 16'h0019, 16'h0028);
    chk(32'(result[7:0]), 32'h47);
    apb(1'b0, cfs_pkg::ADDR_CCR, 32'h0);
    chk(32'(rdat[13]), 32'h1);
    ex(cfs_pkg::OP_BCD, 1'b1, 16'h0011, 16'h0011);
    apb(1'b0, cfs_pkg::ADDR_CCR, 32'h0);
    chk({rdat[13], 7'h0, result[7:0]}, 32'h22);
    // Halt: no-op while stop bit set, stops clock when clear
    ex(cfs_pkg::OP_STOP, 1'b0, 16'h0, 16'h0);
    chk(32'(clock_stop), 32'h0);
    apb(1'b1, cfs_pkg::ADDR_CCR, 32'h00e0);
    ex(cfs_pkg::OP_STOP, 1'b0, 16'h0, 16'h0);
    chk(32'(clock_stop), 32'h1);
    apb(1'b0, cfs_pkg::ADDR_STAT, 32'h0);
    chk(rdat & 32'h1, 32'h1);
    @(posedge pclk);
    wake <= 1'b1;
    @(posedge pclk);
    wake <= 1'b0;
    @(posedge pclk);
    #1;
    chk(32'(clock_stop), 32'h0);
    // Priority mask
    irq(3'h7, 1'b0);
    apb(1'b1, cfs_pkg::ADDR_CCR, 32'h8066);
    irq(3'h4, 1'b1);
    irq(3'h3, 1'b0);
    // Bank fields and address forming
    apb(1'b1, cfs_pkg::ADDR_EXT, 32'h1234);
    apb(1'b1, cfs_pkg::ADDR_SK, 32'h5);
    apb(1'b0, cfs_pkg::ADDR_EXT, 32'h0);
    chk(rdat, 32'h1234);
    ac(cfs_pkg::K_FETCH, 16'h1235, 1'b1);
    chk({bus.valid, bus.prog, bus.byte_sz, bus.addr}, {3'b110, 20'h61234});
    ac(cfs_pkg::K_RVEC, 16'h0002, 1'b1);
    chk({bus.prog, bus.addr[15:0]}, {1'b1, 16'h0002});
    ac(cfs_pkg::K_VEC, 16'h0010, 1'b1);
    chk({bus.prog, bus.addr}, {1'b0, 20'h00010});
    for (int k = 0; k < 5; k++)
    begin
      ac(cfs_pkg::cfs_kind_e'(3 + k), 16'hab00, 1'b1);
      chk({bus.valid, bus.prog, bus.addr}, {2'b10, bank[k], 16'hab00});
    end
    // Misaligned word splits into two byte transfers across a bank edge
    ac(cfs_pkg::K_X, 16'hffff, 1'b1);
    chk({acc_busy, bus.byte_sz, bus.lane_hi, bus.addr}, {3'b111, 20'h2ffff});
    @(posedge pclk);
    #1;
    chk({acc_busy, bus.byte_sz, bus.lane_hi, bus.addr}, {3'b010, 20'h30000});
    // Accumulate, overflow flags and saturation
    apb(1'b1, cfs_pkg::ADDR_MUL, 32'h7fff);
    apb(1'b1, cfs_pkg::ADDR_MCAND, 32'h7fff);
    apb(1'b1, cfs_pkg::ADDR_AM_LO, 32'h7fffffff);
    apb(1'b1, cfs_pkg::ADDR_AM_HI, 32'h0);
    ex(cfs_pkg::OP_MAC, 1'b0, 16'h0, 16'h0);
    apb(1'b0, cfs_pkg::ADDR_AM_LO, 32'h0);
    chk(rdat, 32'hfffe0001);
    apb(1'b0, cfs_pkg::ADDR_CCR, 32'h0);
    chk(32'(rdat[14:12]), 32'h1);
    apb(1'b1, cfs_pkg::ADDR_AM_LO, 32'hffffffff);
    apb(1'b1, cfs_pkg::ADDR_AM_HI, 32'h7);
    ex(cfs_pkg::OP_MAC, 1'b0, 16'h0, 16'h0);
    apb(1'b0, cfs_pkg::ADDR_AM_HI, 32'h0);
    chk(rdat, 32'h8);
    apb(1'b0, cfs_pkg::ADDR_CCR, 32'h0);
    chk(32'(rdat[14]), 32'h1);
    apb(1'b1, cfs_pkg::ADDR_CCR, 32'h90f0 | 32'h4000);
    ex(cfs_pkg::OP_TRANSFER_ACC_ROUNDED, 1'b0, 16'h0, 16'h0);
    chk(32'(xfer_data), 32'(cfs_pkg::SAT_POS));
    ex(cfs_pkg::OP_TRANSFER_ACC_TRUNCATED, 1'b0, 16'h0, 16'h0);
    chk(32'(xfer_data), 32'(cfs_pkg::SAT_POS));
    // Modulo masks read back as written
    apb(1'b1, cfs_pkg::ADDR_MASK, 32'ha55a);
    apb(1'b0, cfs_pkg::ADDR_MASK, 32'h0);
    chk(rdat, 32'ha55a);
    // Without saturation the transfers round or truncate the upper word
    apb(1'b1, cfs_pkg::ADDR_CCR, 32'h00e0);
    apb(1'b1, cfs_pkg::ADDR_AM_LO, 32'h12348000);
    ex(cfs_pkg::OP_TRANSFER_ACC_ROUNDED, 1'b0, 16'h0, 16'h0);
    chk(32'(xfer_data), 32'h1235);
    ex(cfs_pkg::OP_TRANSFER_ACC_TRUNCATED, 1'b0, 16'h0, 16'h0);
    chk(32'(xfer_data), 32'h1234);
    // Negative accumulator overflowing downward saturates to the negative limit
    apb(1'b1, cfs_pkg::ADDR_MUL, 32'h8000);
    apb(1'b1, cfs_pkg::ADDR_AM_HI, 32'h8);
    apb(1'b1, cfs_pkg::ADDR_AM_LO, 32'h0);
    ex(cfs_pkg::OP_MAC, 1'b0, 16'h0, 16'h0);
    apb(1'b1, cfs_pkg::ADDR_CCR, 32'h40f0);
    ex(cfs_pkg::OP_TRANSFER_ACC_TRUNCATED, 1'b0, 16'h0, 16'h0);
    chk(32'(xfer_data), 32'(cfs_pkg::SAT_NEG));
    apb(1'b0, cfs_pkg::ADDR_STAT, 32'h0);
    chk(rdat & 32'h2, 32'h2);
    // Reset in mid-run restores the register defaults
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    #1;
    chk({clock_stop, irq_take, pready, bus.valid}, 32'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, cfs_pkg::ADDR_CCR, 32'h0);
    chk(rdat, 32'(cfs_pkg::CCR_RST));
    apb(1'b0, cfs_pkg::ADDR_EXT, 32'h0);
    chk(rdat, 32'(cfs_pkg::EXT_RST));
    results();
  end
endmodule : cfs_flags_bench
